// ---- hw/cpwd_top.sv ----
// supervision system: watchdog, slow-clock detector, stop control, apb registers
// Behaviour
// - watchdog is a free 21-stage counter on oscillator edges, 2,097,152 edges
// - terminal count forces a supervision reset using the supervision vector
// - writing $55 then $AA to the restart key register clears the counter
// - no limit on time between the two key writes
// - overflow sets overflow_flag, bit 0 of the status register
// - any restart-key write with bit 0 zero clears overflow_flag
// - only power-on reset clears the flag; pin and slow resets keep it
// - status reads zeros in bits 7..2, one in bit 1, flag in bit 0
// - watchdog cannot be disabled; pin reset returns counter to zero
// - timeout scales inversely with oscillator rate, about 210ms at 10 MHz
// - each oscillator rising edge restarts slow timer; its limit forces reset
// - supervision reset acts as a full reset but selects the supervision vector
// - after supervision reset hold 4064 clocks, slow detection inhibited
// - detector not disableable; pin reset holds it until start-up and pin high
// - stop mode inhibits watchdog and slow-clock detector
// - stop ends only on interrupt low, receive falling edge, pin reset or power-on
// - after stop wait 4064 cycles, or 96 when short wake delay is set
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module cpwd_top
    import cpwd_pkg::*;
#(
    parameter int SLOW_LIMIT = SLOW_CYCLES,
    parameter int WD_BITS    = WD_STAGES
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [cpwd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    oscillator_input,
    input  wire logic                    reset_pin_n,
    input  wire logic                    irq_n,
    input  wire logic                    bus_receive_input,
    input  wire logic                    stop_req,
    input  wire logic                    short_wake_delay,
    output logic                         core_reset,
    output logic                         core_stall,
    output logic                         supervision_vector,
    output logic                         supervision_event
);
    import cpwd_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hits = (a == ADDR_W'({idx, 2'b00}));
    endfunction

    cpwd_state_t            state_reg;
    cpwd_state_t            state_next;
    logic [WD_BITS-1:0]     wd_cnt_reg;
    logic [15:0]            slow_cnt_reg;
    logic                   overflow_flag_reg;
    logic                   key_armed_reg;
    logic                   osc_prev_reg;
    logic                   rx_prev_reg;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   core_reset_reg;
    logic                   core_stall_reg;
    logic                   sup_vector_reg;
    logic                   sup_event_reg;
    logic                   short_sel_reg;
    logic                   start_done;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // access completes in the access phase with no wait state
    wire acc       = psel && penable && pready_reg;
    wire hit_key   = hits(paddr, KEY_IDX);
    wire hit_stat  = hits(paddr, STAT_IDX);
    wire mapped    = (hit_key && pwrite) || (hit_stat && !pwrite);
    wire key_wr    = acc && pwrite && hit_key;
    wire stat_rd   = acc && !pwrite && hit_stat;
    wire [7:0] key_data = pwdata[7:0];
    wire [7:0] stat_val = STAT_FIXED | {7'h00, overflow_flag_reg};

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    wire osc_rise   = oscillator_input && !osc_prev_reg;
    wire rx_fall    = !bus_receive_input && rx_prev_reg;
    wire running    = (state_reg == CPWD_RUN);
    wire wd_term    = running && osc_rise && (&wd_cnt_reg);
    wire slow_trip  = running && reset_pin_n && !osc_rise &&
                      (slow_cnt_reg == 16'(SLOW_LIMIT - 1));
    wire sup_reset  = wd_term || slow_trip;
    wire key_done   = key_wr && key_armed_reg && (key_data == KEY_SECOND);
    wire pin_low    = !reset_pin_n;
    wire wake       = !irq_n || rx_fall;
    wire start_clr  = sup_reset || pin_low || (state_reg == CPWD_STOP);
    wire [START_W-1:0] start_tgt = short_sel_reg ? SHORT_CYCLES : STARTUP_CYCLES;

    // ------------------------------------------------------------
    // start-up delay timer
    // ------------------------------------------------------------
    cpwd_startup_timer #(
        .W(START_W)
    ) u_start (
        .clk     (pclk),
        .rst_n   (presetn),
        .restart (start_clr),
        .tick    (osc_rise),
        .target  (start_tgt),
        .done    (start_done)
    );

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    // pin reset outranks all; supervision reset re-enters hold
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CPWD_RUN: begin
                if (sup_reset) begin
                    state_next = CPWD_HOLD;
                end else if (stop_req) begin
                    state_next = CPWD_STOP;
                end
            end
            CPWD_HOLD: begin
                if (start_done && !pin_low) begin
                    state_next = CPWD_RUN;
                end
            end
            CPWD_STOP: begin
                if (wake) begin
                    state_next = CPWD_WAKE;
                end
            end
            CPWD_WAKE: begin
                if (start_done) begin
                    state_next = CPWD_RUN;
                end
            end
            default: begin
                state_next = CPWD_HOLD;
            end
        endcase
        if (pin_low) begin
            state_next = CPWD_HOLD;
        end
    end

    // power-on starts in hold so the start-up delay is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CPWD_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // the delay length is chosen on the way into stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_sel_reg <= 1'b0;
        end else if (state_next == CPWD_HOLD) begin
            short_sel_reg <= 1'b0;
        end else if (running && stop_req) begin
            short_sel_reg <= short_wake_delay;
        end
    end

    // ------------------------------------------------------------
    // input edge history
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_reg <= 1'b0;
            rx_prev_reg  <= 1'b1;
        end else begin
            osc_prev_reg <= oscillator_input;
            rx_prev_reg  <= bus_receive_input;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    // no enable bit exists; only run state lets it count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_reg <= '0;
        end else if (state_reg == CPWD_HOLD || sup_reset || key_done) begin
            wd_cnt_reg <= '0;
        end else if (running && osc_rise) begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    // key sequence: $55 arms, $AA completes, anything else disarms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_armed_reg <= 1'b0;
        end else if (state_reg == CPWD_HOLD) begin
            key_armed_reg <= 1'b0;
        end else if (key_wr) begin
            key_armed_reg <= (key_data == KEY_FIRST);
        end
    end

    // ------------------------------------------------------------
    // slow-clock detector
    // ------------------------------------------------------------
    // cleared by every oscillator rising edge and outside run state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt_reg <= '0;
        end else if (!running || osc_rise || slow_trip || pin_low) begin
            slow_cnt_reg <= '0;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------
    // only presetn clears it as power-on; set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_reg <= 1'b0;
        end else if (wd_term) begin
            overflow_flag_reg <= 1'b1;
        end else if (key_wr && !key_data[FLAG_BIT]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RESET_WORD;
        end else begin
            pready_reg  <= psel && !penable;
            pslverr_reg <= psel && !penable && !mapped;
            prdata_reg  <= (psel && !penable && !pwrite && hit_stat) ?
                           {24'h000000, stat_val} : RESET_WORD;
        end
    end

    // ------------------------------------------------------------
    // reset and stall outputs
    // ------------------------------------------------------------
    // vector choice persists until a pin reset selects the normal one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_reg <= 1'b1;
            core_stall_reg <= 1'b0;
            sup_vector_reg <= 1'b0;
            sup_event_reg  <= 1'b0;
        end else begin
            core_reset_reg <= (state_next == CPWD_HOLD);
            core_stall_reg <= (state_next == CPWD_STOP) || (state_next == CPWD_WAKE);
            sup_event_reg  <= sup_reset && !pin_low;
            if (pin_low) begin
                sup_vector_reg <= 1'b0;
            end else if (sup_reset) begin
                sup_vector_reg <= 1'b1;
            end
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign core_reset         = core_reset_reg;
    assign core_stall         = core_stall_reg;
    assign supervision_vector = sup_vector_reg;
    assign supervision_event  = sup_event_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        wd_term |=> overflow_flag_reg && core_reset_reg)
        else $error("overflow did not set flag and reset");

    chk_key_restart: assert property (@(posedge pclk) disable iff (!presetn)
        key_done |=> (wd_cnt_reg == '0) && !key_armed_reg)
        else $error("key pair did not clear watchdog");

    chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (key_wr && !key_data[FLAG_BIT] && !wd_term) |=> !overflow_flag_reg)
        else $error("even key write left flag set");

    chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_stat) |=>
            (prdata[7:1] == 7'h01) && (prdata[0] == $past(overflow_flag_reg)) && pready)
        else $error("status read value wrong");

    chk_slow_reset: assert property (@(posedge pclk) disable iff (!presetn)
        slow_trip |=> core_reset_reg && supervision_event ##1 !supervision_event)
        else $error("slow clock did not force reset");

    chk_stop_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == CPWD_STOP) |=> $stable(wd_cnt_reg) && (slow_cnt_reg == '0))
        else $error("counting while stopped");

    chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == CPWD_STOP && irq_n && !rx_fall && reset_pin_n) |=> core_stall)
        else $error("left stop without wake source");

    chk_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
        pin_low |=> core_reset && !supervision_vector && (slow_cnt_reg == '0))
        else $error("pin reset not held");

    chk_key_abandon: assert property (@(posedge pclk) disable iff (!presetn)
        (key_wr && key_data != KEY_FIRST && state_reg != CPWD_HOLD) |=> !key_armed_reg)
        else $error("key sequence not abandoned");

    chk_hold_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == CPWD_HOLD && !start_done) |=>
            core_reset && (slow_cnt_reg == '0) && !supervision_event)
        else $error("supervision reset during start-up");
endmodule

// ---- hw/cpwd_pkg.sv ----
// package of constants and types for the supervision watchdog block
package cpwd_pkg;
    // ------------------------------------------------------------
    // register map (printed offsets are indices; byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  KEY_IDX         = 8'h1D;
    localparam logic [7:0]  STAT_IDX        = 8'h1E;
    localparam logic [7:0]  KEY_FIRST       = 8'h55;
    localparam logic [7:0]  KEY_SECOND      = 8'hAA;
    localparam int          FLAG_BIT        = 0;
    localparam int          ONE_BIT         = 1;
    localparam logic [7:0]  STAT_FIXED      = 8'h02;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          WD_STAGES       = 21;
    localparam int          START_W         = 12;
    localparam logic [11:0] STARTUP_CYCLES  = 12'hFE0;
    localparam logic [11:0] SHORT_CYCLES    = 12'h060;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          SLOW_PERIOD_NS  = 5000;
    localparam int          SLOW_CYCLES     = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // sequencing states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CPWD_RUN,
        CPWD_HOLD,
        CPWD_STOP,
        CPWD_WAKE
    } cpwd_state_t;
endpackage

// ---- hw/cpwd_startup_timer.sv ----
// start-up delay counter, counts oscillator edges up to a target
`timescale 1ns/1ps
module cpwd_startup_timer #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         restart,
    input  wire logic         tick,
    input  wire logic [W-1:0] target,
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic         done_reg;
    wire          reached = (cnt_reg == target);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // restart wins over counting; done holds once reached
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else if (restart) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            if (tick && !reached) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            done_reg <= reached;
        end
    end

    assign done = done_reg;
endmodule

// ---- bench/cpwd_testbench.sv ----
// self-checking testbench for the supervision watchdog block
`timescale 1ns/1ps
module testbench;
    import cpwd_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observation signals
    // ------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc = 1'b0;
    logic        osc_run = 1'b1;
    logic [1:0]  div = 2'h0;
    logic        pin_n = 1'b1;
    logic        irq_n = 1'b1;
    logic        rx_in = 1'b1;
    logic        stop_req = 1'b0;
    logic        short_dly = 1'b0;
    logic        core_reset;
    logic        core_stall;
    logic        sup_vec;
    logic        sup_evt;
    int          edges = 0;
    int          events = 0;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic        err;
    localparam logic [7:0] KEY_ADDR = {KEY_IDX[5:0], 2'b00};
    localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
    localparam int         WD_TEST   = 8;
    localparam int         WD_SPAN   = 1 << WD_TEST;

    // short watchdog so that an overflow fits in the run
    cpwd_top #(.SLOW_LIMIT(20), .WD_BITS(WD_TEST)) dut_u (
        .pclk               (pclk),
        .presetn            (presetn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .oscillator_input   (osc),
        .reset_pin_n        (pin_n),
        .irq_n              (irq_n),
        .bus_receive_input  (rx_in),
        .stop_req           (stop_req),
        .short_wake_delay   (short_dly),
        .core_reset         (core_reset),
        .core_stall         (core_stall),
        .supervision_vector (sup_vec),
        .supervision_event  (sup_evt)
    );

    // ------------------------------------------------------------
    // clock, oscillator (period of 4 pclk) and event counters
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;

    // oscillator freezes low-or-high when stopped, edges counted here
    always @(posedge pclk) begin
        if (osc_run) begin
            div <= div + 2'h1;
            if (div[0]) begin
                osc <= ~osc;
            end
            if (div[0] && !osc) begin
                edges <= edges + 1;
            end
        end
        if (sup_evt === 1'b1) begin
            events <= events + 1;
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_edges(input int n);
        int t;
        t = edges + n;
        while (edges < t) begin
            @(posedge pclk);
        end
    endtask

    // held until n oscillator edges, then released within a few cycles
    task automatic check_hold(input int n, input logic stall);
        int k;
        k = 0;
        wait_edges(n - 4);
        chk({31'h0, stall ? core_stall : core_reset}, 32'h1);
        while ((stall ? core_stall : core_reset) !== 1'b0 && k < 60) begin
            k++;
            @(posedge pclk);
        end
        chk({31'h0, stall ? core_stall : core_reset}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        chk({31'h0, core_reset}, 32'h1);
        check_hold(4064, 1'b0);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0002);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic t_apb_refusals();
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, KEY_ADDR, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, STAT_ADDR, 32'hFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0002);
    endtask

    task automatic t_key_sequence();
        int w;
        apb(1'b1, KEY_ADDR, 32'h55);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, KEY_ADDR, 32'h11);
        w = dut_u.wd_cnt_reg;
        apb(1'b1, KEY_ADDR, 32'hAA);
        chk({31'h0, dut_u.wd_cnt_reg >= w}, 32'h1);
        apb(1'b1, KEY_ADDR, 32'h55);
        apb(1'b0, STAT_ADDR, 32'h0);
        apb(1'b1, KEY_ADDR, 32'hAA);
        chk({31'h0, err}, 32'h0);
        chk({31'h0, dut_u.wd_cnt_reg < 2}, 32'h1);
        chk({31'h0, core_reset}, 32'h0);
    endtask

    // watchdog left alone overflows after WD_SPAN oscillator edges
    task automatic t_overflow();
        int base;
        int e0;
        int k;
        base = events;
        e0 = edges;
        k = 0;
        while (events == base && k < 1500) begin
            k++;
            @(posedge pclk);
        end
        chk(events - base, 1);
        chk({31'h0, (edges - e0 >= WD_SPAN - 4) && (edges - e0 <= WD_SPAN + 2)}, 32'h1);
        repeat (3) @(posedge pclk);
        chk({30'h0, core_reset, sup_vec}, 32'h3);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0003);
    endtask

    task automatic t_slow_clock();
        int base;
        int k;
        base = events;
        k = 0;
        osc_run <= 1'b0;
        while (events == base && k < 100) begin
            k++;
            @(posedge pclk);
        end
        chk(events - base, 1);
        repeat (3) @(posedge pclk);
        chk({30'h0, core_reset, sup_vec}, 32'h3);
        repeat (100) @(posedge pclk);
        chk(events - base, 1);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0003);
        osc_run <= 1'b1;
        check_hold(4064, 1'b0);
        chk({31'h0, sup_vec}, 32'h1);
        apb(1'b1, KEY_ADDR, 32'h10);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0002);
    endtask

    task automatic t_pin_reset();
        pin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({30'h0, core_reset, sup_vec}, 32'h2);
        wait_edges(50);
        pin_n <= 1'b1;
        check_hold(4064, 1'b0);
        apb(1'b0, STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_0003);
    endtask

    task automatic t_stop(input logic use_rx, input int dly);
        int base;
        base = events;
        short_dly <= (dly == 96);
        stop_req <= 1'b1;
        @(posedge pclk);
        stop_req <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, core_stall}, 32'h1);
        osc_run <= 1'b0;
        repeat (200) @(posedge pclk);
        chk(events - base, 0);
        chk({31'h0, core_stall}, 32'h1);
        osc_run <= 1'b1;
        if (use_rx) begin
            rx_in <= 1'b0;
        end else begin
            irq_n <= 1'b0;
        end
        repeat (3) @(posedge pclk);
        rx_in <= 1'b1;
        irq_n <= 1'b1;
        check_hold(dly, 1'b1);
        chk({31'h0, core_reset}, 32'h0);
    endtask

    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_power_up();
        t_apb_refusals();
        t_key_sequence();
        t_overflow();
        t_pin_reset();
        t_slow_clock();
        t_stop(1'b0, 4064);
        t_stop(1'b1, 96);
        end_sim();
    end

    initial begin
        #1_000_000;
        mismatches++;
        end_sim();
    end
endmodule
